// ==== rtl/bcc_pkg.sv ====
package bcc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ID_ADDR = 8'h00; // identification dword
    localparam logic [7:0] CMD_ADDR = 8'h04; // command (low) and status (high)
    localparam logic [7:0] DEC_ADDR = 8'h08; // registered decode and control results probe port
    localparam logic [7:0] EVT_ADDR = 8'h0C; // spare address, not decoded; reads and writes answer slverr

    // ------------------------------------------------------------
    // identification (values arbitrary, neutral)
    // ------------------------------------------------------------
    localparam logic [15:0] MAKER_ID = 16'hA5A5; // arbitrary maker code
    localparam logic [15:0] PART_ID = 16'h0001; // arbitrary part code

    // ------------------------------------------------------------
    // command field positions
    // ------------------------------------------------------------
    localparam int CMD_IO = 0; // i/o space enable
    localparam int CMD_MEM = 1; // memory space enable
    localparam int CMD_MASTER = 2; // bus master enable
    localparam int CMD_SPECIAL = 3; // special cycles, always zero
    localparam int CMD_MWI = 4; // memory write and invalidate, zero
    localparam int CMD_PALETTE = 5; // palette snoop enable
    localparam int CMD_PARITY = 6; // parity error response
    localparam int CMD_STEP = 7; // stepping, always zero
    localparam int CMD_SYSERR = 8; // system error driver enable
    localparam int CMD_FBB = 9; // fast back-to-back enable
    localparam int STS_PARITY = 24; // data parity error detected

    // writable command bits and reset value
    localparam logic [15:0] CMD_WMASK = 16'h0367;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ------------------------------------------------------------
    // palette decode
    // ------------------------------------------------------------
    localparam logic [9:0] PAL_A = 10'h3C6; // palette mask address
    localparam logic [9:0] PAL_B = 10'h3C8; // palette write index
    localparam logic [9:0] PAL_C = 10'h3C9; // palette data

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/bcc_reg_if.sv ====
`timescale 1ns/10ps
// carries register access events from the bus slave to the register bank
interface bcc_reg_if;
    logic wr_en; // one-cycle write strobe
    logic [7:0] wr_addr; // byte address of write
    logic [31:0] wr_data; // write data
    logic [3:0] wr_strb; // byte enables
    logic [7:0] rd_addr; // read address
    logic [31:0] rd_data; // read data for rd_addr
    logic rd_hit; // rd_addr is mapped
    logic wr_hit; // wr_addr is mapped

    modport slave (
        output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        input rd_data, rd_hit, wr_hit
    );
    modport bank (
        input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        output rd_data, rd_hit, wr_hit
    );
endinterface

// ==== rtl/bcc_axil_slave.sv ====
`timescale 1ns/10ps
// axi4-lite slave: one write and one read at a time
module bcc_axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read address and data
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register bank side
    bcc_reg_if.slave rif
);

    // ------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------
    logic aw_full_q, aw_full_d; // address captured
    logic w_full_q, w_full_d; // data captured
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic do_wr; // both halves present, commit now

    assign s_awready = !aw_full_q && !bvalid_q;
    assign s_wready = !w_full_q && !bvalid_q;
    assign do_wr = aw_full_q && w_full_q && !bvalid_q;

    // next state for write path
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_awvalid && s_awready) begin
            aw_full_d = 1'b1;
            awaddr_d = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_full_d = 1'b1;
            wdata_d = s_wdata;
            wstrb_d = s_wstrb;
        end
        if (do_wr) begin
            // commit and answer
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = rif.wr_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // register write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    assign rif.wr_en = do_wr;
    assign rif.wr_addr = awaddr_q;
    assign rif.wr_data = wdata_q;
    assign rif.wr_strb = wstrb_q;
    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    assign s_arready = !rvalid_q;
    assign rif.rd_addr = s_araddr;

    // next state for read path
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_arvalid && s_arready) begin
            rvalid_d = 1'b1;
            rdata_d = rif.rd_hit ? rif.rd_data : 32'h00000000;
            rresp_d = rif.rd_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_rready) begin
            rvalid_d = 1'b0;
        end
    end

    // register read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;

endmodule // bcc_axil_slave

// ==== rtl/bcc_regs.sv ====
`timescale 1ns/10ps
// register bank: command bits and parity status
module bcc_regs (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus side
    bcc_reg_if.bank rif,
    // parity error input, active low
    input wire logic primary_parity_error_n,
    // command state out
    output logic [15:0] cmd,
    output logic parity_seen
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] cmd_q, cmd_d; // writable command bits
    logic perr_q, perr_d; // sticky parity detected
    logic [15:0] wmask; // bits written by this access

    // byte-enable gated mask of writable command bits
    function automatic logic [15:0] cmd_mask(input logic [3:0] strb);
        cmd_mask = {{8{strb[1]}}, {8{strb[0]}}} & bcc_pkg::CMD_WMASK;
    endfunction

    // next values
    always_comb begin
        cmd_d = cmd_q;
        perr_d = perr_q;
        wmask = cmd_mask(rif.wr_strb);
        if (rif.wr_en && rif.wr_addr == bcc_pkg::CMD_ADDR) begin
            // read-only bits never change
            cmd_d = (cmd_q & ~wmask) | (rif.wr_data[15:0] & wmask); // [RQ16]
            // write one clears the parity flag
            if (rif.wr_strb[3] && rif.wr_data[bcc_pkg::STS_PARITY]) begin
                perr_d = 1'b0; // [RQ15]
            end
        end
        // a new event wins over a clear in the same cycle
        if (!primary_parity_error_n && cmd_q[bcc_pkg::CMD_PARITY]) begin
            perr_d = 1'b1; // [RQ15]
        end
    end

    // register the bank
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_q <= bcc_pkg::CMD_RESET; // [RQ3] [RQ4] [RQ5] [RQ10] [RQ12] [RQ13]
            perr_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            perr_q <= perr_d;
        end
    end

    assign cmd = cmd_q & bcc_pkg::CMD_WMASK; // [RQ7] [RQ8] [RQ11] [RQ14]
    assign parity_seen = perr_q;

endmodule // bcc_regs

// ==== rtl/bcc_top.sv ====
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
// Contract
// [RQ1] dword zero low half: fixed maker code
// [RQ2] dword zero high half: fixed part code
// [RQ3] bit 0 gates primary i/o response; palette i/o writes here follow bit 5 alone, whatever bit 0 holds
// [RQ4] bit 1 gates primary memory response
// [RQ5] bit 2 clear: no mastering, no secondary
// [RQ6] bit 2 set: forward secondary to primary
// [RQ7] bit 3 read-only zero
// [RQ8] bit 4 read-only zero
// [RQ9] bit 5 enables palette write decode
// [RQ10] bit 6 enables parity error action
// [RQ11] bit 7 read-only zero
// [RQ12] bit 8 gates system error driver
// [RQ13] bit 9 gates fast back-to-back
// [RQ14] bits 15:10 read zero
// [RQ15] parity event sets status 24, w1c; the code sets it only while bit 6 is set
// [RQ16] read-only bits ignore writes; byte enables
module bcc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // primary bus decode request
    input wire logic p_req,
    input wire logic p_is_io,
    input wire logic p_is_write,
    input wire logic [15:0] p_addr,
    output logic p_claim,
    // secondary bus decode request
    input wire logic s_req,
    output logic s_claim,
    // primary master control
    input wire logic fwd_req,
    input wire logic fwd_mwi,
    input wire logic fwd_b2b_diff,
    output logic p_master_go,
    output logic p_mwi_ok,
    output logic p_fbb_ok,
    output logic addr_step_en,
    // parity and system error
    input wire logic primary_parity_error_n,
    input wire logic serr_event,
    output logic parity_action,
    output logic primary_system_error_n_o,
    output logic primary_system_error_n_oe
);

    // ------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------
    bcc_reg_if rif (); // slave to bank link
    logic [15:0] cmd; // effective command bits
    logic parity_seen; // sticky status bit 24

    // bus slave
    bcc_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rif(rif.slave)
    );

    // command and status bank
    bcc_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .rif(rif.bank),
        .primary_parity_error_n(primary_parity_error_n),
        .cmd(cmd),
        .parity_seen(parity_seen)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // true for a palette register address, alias bits 15:10 ignored
    function automatic logic is_palette(input logic [15:0] a);
        is_palette = (a[9:0] == bcc_pkg::PAL_A) || (a[9:0] == bcc_pkg::PAL_B)
            || (a[9:0] == bcc_pkg::PAL_C);
    endfunction

    // ------------------------------------------------------------
    // registered decode results
    // ------------------------------------------------------------
    logic p_claim_q, p_claim_d;
    logic s_claim_q, s_claim_d;
    logic go_q, go_d;
    logic mwi_q, mwi_d;
    logic fbb_q, fbb_d;
    logic pact_q, pact_d;
    logic serr_oe_q, serr_oe_d;

    // next decode values
    always_comb begin
        p_claim_d = 1'b0;
        if (p_req) begin
            if (p_is_io) begin
                p_claim_d = cmd[bcc_pkg::CMD_IO]; // [RQ3]
                if (p_is_write && is_palette(p_addr)) begin
                    p_claim_d = cmd[bcc_pkg::CMD_PALETTE]; // [RQ9]
                end
            end else begin
                p_claim_d = cmd[bcc_pkg::CMD_MEM]; // [RQ4]
            end
        end
        // secondary claims only with mastering allowed
        s_claim_d = s_req && cmd[bcc_pkg::CMD_MASTER]; // [RQ5]
        go_d = fwd_req && cmd[bcc_pkg::CMD_MASTER]; // [RQ5] [RQ6]
        // mwi only passed through on forwarded traffic
        mwi_d = fwd_req && fwd_mwi && cmd[bcc_pkg::CMD_MASTER]; // [RQ8]
        fbb_d = fwd_b2b_diff && cmd[bcc_pkg::CMD_FBB]; // [RQ13]
        pact_d = !primary_parity_error_n && cmd[bcc_pkg::CMD_PARITY]; // [RQ10]
        // drive the pin low only while enabled and an event is up
        serr_oe_d = serr_event && cmd[bcc_pkg::CMD_SYSERR]; // [RQ12]
    end

    // register decode results
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p_claim_q <= 1'b0;
            s_claim_q <= 1'b0;
            go_q <= 1'b0;
            mwi_q <= 1'b0;
            fbb_q <= 1'b0;
            pact_q <= 1'b0;
            serr_oe_q <= 1'b0;
        end else begin
            p_claim_q <= p_claim_d;
            s_claim_q <= s_claim_d;
            go_q <= go_d;
            mwi_q <= mwi_d;
            fbb_q <= fbb_d;
            pact_q <= pact_d;
            serr_oe_q <= serr_oe_d;
        end
    end

    assign p_claim = p_claim_q;
    assign s_claim = s_claim_q;
    assign p_master_go = go_q;
    assign p_mwi_ok = mwi_q;
    assign p_fbb_ok = fbb_q;
    assign parity_action = pact_q;
    assign addr_step_en = cmd[bcc_pkg::CMD_STEP]; // [RQ11]
    assign primary_system_error_n_o = 1'b0;
    assign primary_system_error_n_oe = serr_oe_q; // [RQ12]

    // ------------------------------------------------------------
    // read mux and address map
    // ------------------------------------------------------------
    always_comb begin
        rif.rd_data = 32'h00000000;
        rif.rd_hit = 1'b1;
        case (rif.rd_addr)
            bcc_pkg::ID_ADDR: rif.rd_data = {bcc_pkg::PART_ID, bcc_pkg::MAKER_ID}; // [RQ1] [RQ2]
            bcc_pkg::CMD_ADDR: begin
                rif.rd_data[15:0] = cmd; // [RQ14]
                rif.rd_data[bcc_pkg::STS_PARITY] = parity_seen; // [RQ15]
            end
            bcc_pkg::DEC_ADDR: rif.rd_data = {25'h0000000, serr_oe_q, pact_q, fbb_q, mwi_q,
                go_q, s_claim_q, p_claim_q};
            default: rif.rd_hit = 1'b0;
        endcase
    end

    // writes to the id dword are accepted and dropped
    assign rif.wr_hit = (rif.wr_addr == bcc_pkg::ID_ADDR) || (rif.wr_addr == bcc_pkg::CMD_ADDR)
        || (rif.wr_addr == bcc_pkg::DEC_ADDR); // [RQ16]

endmodule // bcc_top

// ==== sim/bcc_chk_asserts.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker for the identification and command bank
// ------------------------------------------------------------
module bcc_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus handshakes
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    // decode and master control
    input wire logic p_req,
    input wire logic p_claim,
    input wire logic s_req,
    input wire logic s_claim,
    input wire logic fwd_req,
    input wire logic fwd_mwi,
    input wire logic fwd_b2b_diff,
    input wire logic p_master_go,
    input wire logic p_mwi_ok,
    input wire logic p_fbb_ok,
    input wire logic addr_step_en,
    // parity and system error
    input wire logic primary_parity_error_n,
    input wire logic serr_event,
    input wire logic parity_action,
    input wire logic primary_system_error_n_o,
    input wire logic primary_system_error_n_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // bus steps
    // ------------------------------------------------------------
    // address and data taken at one edge
    sequence s_wr_both;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    // read address taken
    sequence s_rd_take;
        s_arvalid && s_arready;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_write_answer: assert property (s_wr_both |-> ##2 s_bvalid)
        else $error("write response missing");
    a_write_refuse: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_rd_take |=> s_rvalid)
        else $error("read data missing");
    a_read_hold: assert property (!(s_arvalid && s_arready) |=> $stable(s_rdata))
        else $error("read data not held");
    a_claim_cause: assert property (p_claim |-> $past(p_req))
        else $error("claim without request");
    a_second_gate: assert property (s_claim |->
        $past(s_req) && p_master_go == $past(fwd_req))
        else $error("secondary claim and mastering disagree");
    a_master_cause: assert property (p_master_go |-> $past(fwd_req))
        else $error("mastering without forwarded request");
    a_mwi_gate: assert property (p_mwi_ok |-> p_master_go && $past(fwd_mwi))
        else $error("invalidate allowed outside forwarding");
    a_fbb_cause: assert property (p_fbb_ok |-> $past(fwd_b2b_diff))
        else $error("back-to-back without request");
    a_step_off: assert property (!addr_step_en)
        else $error("stepping enable raised");
    a_parity_cause: assert property (parity_action |-> !$past(primary_parity_error_n))
        else $error("parity action without error");
    a_serr_drive: assert property (primary_system_error_n_oe |->
        !primary_system_error_n_o && $past(serr_event))
        else $error("system error driver wrong");
endmodule // bcc_chk

bind bcc_top bcc_chk u_chk (.aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
    .s_bvalid, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .p_req, .p_claim,
    .s_req, .s_claim, .fwd_req, .fwd_mwi, .fwd_b2b_diff, .p_master_go, .p_mwi_ok, .p_fbb_ok,
    .addr_step_en, .primary_parity_error_n, .serr_event, .parity_action,
    .primary_system_error_n_o, .primary_system_error_n_oe);

// ==== sim/bcc_pbus_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// primary bus agent: one decode request, reports the claim
// ------------------------------------------------------------
module bcc_pbus_model (
    // clock
    input wire logic aclk,
    // request lines into the bridge
    output logic p_req,
    output logic p_is_io,
    output logic p_is_write,
    output logic [15:0] p_addr,
    // bridge answer
    input wire logic p_claim
);
    // idle bus at time zero
    initial begin
        p_req = 1'b0;
        p_is_io = 1'b0;
        p_is_write = 1'b0;
        p_addr = 16'h0000;
    end

    // one-cycle request; released lines show the inverse, not the last value
    task automatic access(input logic [1:0] k, input logic [15:0] a, output logic c);
        @(posedge aclk);
        p_req <= 1'b1;
        p_is_io <= k[1];
        p_is_write <= k[0];
        p_addr <= a;
        @(posedge aclk);
        p_req <= 1'b0;
        p_is_io <= ~k[1];
        p_is_write <= ~k[0];
        p_addr <= ~a;
        #1 c = p_claim;
    endtask
endmodule // bcc_pbus_model

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// bench for the identification and command bank
// ------------------------------------------------------------
module tb_top;
    // clock, reset and register bus
    logic aclk, aresetn;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    // primary, secondary and error side
    logic [15:0] p_addr;
    logic p_req, p_is_io, p_is_write, p_claim, s_req, s_claim;
    logic fwd_req, fwd_mwi, fwd_b2b_diff, p_master_go, p_mwi_ok, p_fbb_ok, addr_step_en;
    logic primary_parity_error_n, serr_event, parity_action;
    logic primary_system_error_n_o, primary_system_error_n_oe;
    int num_errors, num_checks;
    logic [15:0] cl [4]; // command patterns for the control loop
    logic [5:0] ex; // expected control outputs
    localparam logic [1:0] OK = bcc_pkg::RESP_OKAY;
    localparam logic [7:0] CA = bcc_pkg::CMD_ADDR;

    bcc_top dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .p_req, .p_is_io, .p_is_write,
        .p_addr, .p_claim, .s_req, .s_claim, .fwd_req, .fwd_mwi, .fwd_b2b_diff, .p_master_go,
        .p_mwi_ok, .p_fbb_ok, .addr_step_en, .primary_parity_error_n, .serr_event,
        .parity_action, .primary_system_error_n_o, .primary_system_error_n_oe);
    bcc_pbus_model u_pbus (.aclk, .p_req, .p_is_io, .p_is_write, .p_addr, .p_claim);

    // 125 MHz clock
    always #4 aclk = ~aclk;

    // ------------------------------------------------------------
    // compare, bus and decode tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // write: address and data together, response awaited
    task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
        input logic [1:0] er);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, er});
    endtask

    // read: ready held until valid is seen, data taken then
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        s_rready <= 1'b0;
        chk(s_rdata, e);
        chk({30'h0, s_rresp}, {30'h0, er});
    endtask

    // set command, present one primary access, compare the claim
    task automatic dec(input logic [15:0] cm, input logic [1:0] k, input logic [15:0] a,
        input logic e);
        logic c;
        wrc(CA, {16'h0000, cm}, 4'hF, OK);
        u_pbus.access(k, a, c);
        chk({31'h0, c}, {31'h0, e});
    endtask

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_req, fwd_req, fwd_mwi, fwd_b2b_diff, serr_event} = '0;
        primary_parity_error_n = 1'b1;
        num_errors = 0;
        num_checks = 0;
        cl = '{16'h0000, 16'h0004, 16'h0340, 16'h0367};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // identification and reset values, writes ignored
        rdc(bcc_pkg::ID_ADDR, {bcc_pkg::PART_ID, bcc_pkg::MAKER_ID}, OK);
        rdc(CA, 32'h0000_0000, OK);
        wrc(bcc_pkg::ID_ADDR, 32'hFFFF_FFFF, 4'hF, OK);
        rdc(bcc_pkg::ID_ADDR, {bcc_pkg::PART_ID, bcc_pkg::MAKER_ID}, OK);
        // read-only command bits and byte lanes
        wrc(CA, 32'hFFFF_FFFF, 4'h3, OK);
        rdc(CA, 32'h0000_0367, OK);
        wrc(CA, 32'h0000_0000, 4'h2, OK);
        rdc(CA, 32'h0000_0067, OK);
        // primary decode: kind 3 i/o write, 2 i/o read, 0 memory read
        dec(16'h0000, 2'h3, 16'h1000, 1'b0);
        dec(16'h0001, 2'h3, 16'h1000, 1'b1);
        dec(16'h0001, 2'h0, 16'h2000, 1'b0);
        dec(16'h0002, 2'h0, 16'h2000, 1'b1);
        dec(16'h0002, 2'h2, 16'h1000, 1'b0);
        dec(16'h0020, 2'h3, 16'hFFC6, 1'b1);
        dec(16'h0020, 2'h3, 16'h03C8, 1'b1);
        dec(16'h0020, 2'h3, 16'h7FC9, 1'b1);
        dec(16'h0020, 2'h3, 16'h03C7, 1'b0);
        dec(16'h0020, 2'h2, 16'h03C6, 1'b0);
        dec(16'h0001, 2'h3, 16'h03C9, 1'b0);
        // control outputs with every request but p_req raised
        @(posedge aclk);
        {s_req, fwd_req, fwd_mwi, fwd_b2b_diff, serr_event} <= 5'h1F;
        primary_parity_error_n <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wrc(CA, {16'h0000, cl[i]}, 4'hF, OK);
            repeat (2) @(posedge aclk);
            ex = {cl[i][8], cl[i][6], cl[i][9], cl[i][2], cl[i][2], cl[i][2]};
            chk({26'h0, primary_system_error_n_oe, parity_action, p_fbb_ok, p_mwi_ok,
                p_master_go, s_claim}, {26'h0, ex});
            rdc(bcc_pkg::DEC_ADDR, {25'h0, ex, 1'b0}, OK);
            rdc(CA, {7'h00, i >= 2, 8'h00, cl[i]}, OK);
        end
        // parity flag cleared by writing one
        @(posedge aclk);
        primary_parity_error_n <= 1'b1;
        wrc(CA, 32'h0100_0000, 4'h8, OK);
        rdc(CA, 32'h0000_0367, OK);
        // unmapped place
        rdc(8'h10, 32'h0000_0000, bcc_pkg::RESP_SLVERR);
        wrc(8'h10, 32'hFFFF_FFFF, 4'hF, bcc_pkg::RESP_SLVERR);
        stop_test();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        $display("watchdog expired at %0t ns", $time);
        stop_test();
    end
endmodule // tb_top
